// >>> inc/eep_pkg.sv
/*
 * Shared constants and types of the two-wire data store slave port.
 * Assumes a 25 MHz system clock; the write cycle count WR_CYC is derived from it here.
 */
package eep_pkg;

   // ***********************************************************
   // array and bus layout
   // ***********************************************************
   localparam int unsigned MEM_WORDS = 128;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned FIFO_W = ADDR_W + DATA_W;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned WR_TIME_NS = 5000;
   localparam int unsigned WR_CYC =
      (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TMR_W = 12;

   // ***********************************************************
   // protocol sequencer states
   // ***********************************************************
   typedef enum logic [9:0] {
      ST_IDLE   = 10'h001,
      ST_DEVADR = 10'h002,
      ST_ACKDEV = 10'h004,
      ST_WRDADR = 10'h008,
      ST_ACKWA  = 10'h010,
      ST_WRDATA = 10'h020,
      ST_ACKWD  = 10'h040,
      ST_RDDATA = 10'h080,
      ST_RDACK  = 10'h100,
      ST_IGNORE = 10'h200
   } eep_state_t;

endpackage

// >>> design/eep_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module eep_fifo #(
   parameter int unsigned WIDTH = 15,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [PW:0] cnt;
   } eep_fifo_regs_t;

   eep_fifo_regs_t q;
   eep_fifo_regs_t d;
   logic [WIDTH-1:0] store [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (q.cnt != DEPTH[PW:0]);
   assign out_valid = (q.cnt != '0);
   assign out_data = store[q.rd];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb
   begin
      d = q;
      if (push)
      begin
         d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop)
      begin
         d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      if (push && !pop)
      begin
         d.cnt = q.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // storage has no reset: contents are meaningless until written
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         store[q.wr] <= in_data;
      end
   end
endmodule

// >>> design/eep_slave.sv
/*
 * Two-wire serial slave port of a 128 x 8 non-volatile data store.
 * Assumes scl and sda come from pins outside the clock domain and that
 * the bus wire is pulled high outside; this block only pulls sda low.
 */
`timescale 1ns/1ps
// Summary of operation
// RULE1: the store holds 128 words of 8 bits reached only over the bus.
// RULE2: incoming data bits are sampled on each rising serial clock edge.
// RULE3: outgoing bits, acknowledge and read data change on falling edges.
// RULE4: the master changes data only while the serial clock is low.
// RULE5: a data change while the clock is high is START or STOP, not data.
// RULE6: the data line is only ever pulled low or released, never driven high.
// RULE7: the master brackets every transfer by START and STOP.
// RULE8: START is a falling data line while the clock is high.
// RULE9: the first seven bits after START must equal the fixed device address.
// RULE10: the eighth bit after START selects read when high, write when low.
// RULE11: each received byte is acknowledged by a low on the ninth pulse; the code omits it for its address while busy and on a full queue.
// RULE12: after a write address byte the word address follows and is acked.
// RULE13: the word address comes msb first and its top bit is ignored.
// RULE14: the host keeps its shared pins as inputs when another master runs.
// RULE15: STOP is a rising data line while the clock is high; then go idle.
// RULE16: the word pointer steps by one per byte and wraps to zero.
// RULE17: a foreign device address leaves the line free until the next START.
module eep_slave #(
   parameter int unsigned WR_CYCLES = eep_pkg::WR_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic busy
);
   import eep_pkg::*;

   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_f;
      logic sda_f;
      eep_state_t state;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic mack;
      logic [ADDR_W-1:0] ptr;
      logic [TMR_W-1:0] tmr;
      logic oe;
      logic busy;
   } eep_regs_t;

   eep_regs_t q;
   eep_regs_t d;
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic [DATA_W-1:0] rd_byte;
   logic f_in_valid;
   logic f_in_ready;
   logic [FIFO_W-1:0] f_in_data;
   logic f_out_valid;
   logic f_out_ready;
   logic [FIFO_W-1:0] f_out_data;

   assign rd_byte = mem[q.ptr];
   assign sda_o = 1'b0; // [RULE6]
   assign sda_oe = q.oe;
   assign busy = q.busy;

   // ***********************************************************
   // pending writes: the internal write cycle drains this queue
   // ***********************************************************
   eep_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   // ***********************************************************
   // sequencer
   // ***********************************************************
   always_comb
   begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      rise = 1'b0;
      fall = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      d = q;
      f_in_valid = 1'b0;
      f_in_data = {q.ptr, q.sh};
      f_out_ready = 1'b0;

      // first stage feeds only the second; level moves when 2 and 3 agree
      d.scl_s = {q.scl_s[1:0], scl_i};
      d.sda_s = {q.sda_s[1:0], sda_i};
      if (q.scl_s[1] == q.scl_s[2])
      begin
         d.scl_f = q.scl_s[2];
      end
      if (q.sda_s[1] == q.sda_s[2])
      begin
         d.sda_f = q.sda_s[2];
      end
      rise = d.scl_f & ~q.scl_f;
      fall = ~d.scl_f & q.scl_f;
      // data moving under a high clock is a condition, never a bit
      start = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f; // [RULE5] [RULE8]
      stop = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f; // [RULE5] [RULE15]

      if (stop)
      begin
         d.state = ST_IDLE; // [RULE15]
         d.oe = 1'b0;
      end
      else if (start)
      begin
         d.state = ST_DEVADR;
         d.cnt = '0;
         d.oe = 1'b0;
      end
      else
      begin
         unique case (q.state)
            ST_IDLE, ST_IGNORE:
            begin
               d.oe = 1'b0; // [RULE17]
            end
            ST_DEVADR, ST_WRDADR, ST_WRDATA:
            begin
               if (rise)
               begin
                  d.sh = {q.sh[6:0], q.sda_f}; // [RULE2]
                  d.cnt = q.cnt + 1'b1;
               end
               else if (fall && q.cnt == BIT_LAST)
               begin
                  if (q.state == ST_DEVADR)
                  begin
                     d.rw = q.sh[0]; // [RULE10]
                     // busy write cycle answers with no acknowledge
                     if (q.sh[7:1] == DEV_ADDR && !q.busy) // [RULE9]
                     begin
                        d.state = ST_ACKDEV;
                        d.oe = 1'b1; // [RULE11]
                     end
                     else
                     begin
                        d.state = ST_IGNORE; // [RULE17]
                     end
                  end
                  else if (q.state == ST_WRDADR)
                  begin
                     d.ptr = q.sh[6:0]; // [RULE13]
                     d.state = ST_ACKWA;
                     d.oe = 1'b1; // [RULE12]
                  end
                  else if (f_in_ready)
                  begin
                     f_in_valid = 1'b1;
                     d.ptr = q.ptr + 1'b1; // [RULE16]
                     d.state = ST_ACKWD;
                     d.oe = 1'b1; // [RULE11]
                  end
                  else
                  begin
                     // queue full: refuse the byte rather than lose it
                     d.state = ST_IGNORE;
                  end
               end
            end
            ST_ACKDEV, ST_ACKWA, ST_ACKWD:
            begin
               if (fall)
               begin
                  d.cnt = '0;
                  d.oe = 1'b0; // [RULE3]
                  if (q.state == ST_ACKDEV && q.rw)
                  begin
                     d.state = ST_RDDATA;
                     d.sh = rd_byte;
                     d.oe = ~rd_byte[7]; // [RULE3]
                  end
                  else if (q.state == ST_ACKDEV)
                  begin
                     d.state = ST_WRDADR; // [RULE12]
                  end
                  else
                  begin
                     d.state = ST_WRDATA;
                  end
               end
            end
            ST_RDDATA:
            begin
               if (rise)
               begin
                  d.cnt = q.cnt + 1'b1;
               end
               else if (fall && q.cnt == BIT_LAST)
               begin
                  d.oe = 1'b0;
                  d.ptr = q.ptr + 1'b1; // [RULE16]
                  d.state = ST_RDACK;
               end
               else if (fall)
               begin
                  d.sh = {q.sh[6:0], 1'b0};
                  d.oe = ~q.sh[6]; // [RULE3]
               end
            end
            ST_RDACK:
            begin
               if (rise)
               begin
                  d.mack = ~q.sda_f; // [RULE2]
               end
               else if (fall && q.mack)
               begin
                  d.state = ST_RDDATA;
                  d.cnt = '0;
                  d.sh = rd_byte;
                  d.oe = ~rd_byte[7]; // [RULE3]
               end
               else if (fall)
               begin
                  d.state = ST_IGNORE;
               end
            end
            default:
            begin
               d.state = ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end

      // internal write cycle runs only while the sequencer is in ST_IDLE or ST_IGNORE
      d.tmr = '0;
      if (f_out_valid && (q.state == ST_IDLE || q.state == ST_IGNORE))
      begin
         if (q.tmr == TMR_W'(WR_CYCLES - 1))
         begin
            f_out_ready = 1'b1;
         end
         else
         begin
            d.tmr = q.tmr + 1'b1;
         end
      end
      else if (f_out_valid)
      begin
         d.tmr = q.tmr;
      end
      d.busy = f_out_valid | f_in_valid;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
                state: ST_IDLE, cnt: 4'h0, sh: 8'h00, rw: 1'b0,
                mack: 1'b0, ptr: 7'h00, tmr: 12'h000, oe: 1'b0,
                busy: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   // ***********************************************************
   // storage array
   // ***********************************************************
   // no reset: the array stands for non-volatile cells
   always_ff @(posedge clk)
   begin
      if (f_out_valid && f_out_ready)
      begin
         mem[f_out_data[FIFO_W-1:DATA_W]] <= f_out_data[DATA_W-1:0]; // [RULE1]
      end
   end
endmodule

// >>> bench/eep_bm.sv
/* Two-wire bus master model for the slave port bench.
   Assumes a 25 MHz clk: scl period 8 clk, 6 clk low and 2 clk high. */
`timescale 1ns/1ps
module eep_bm (
   input wire logic clk,
   input wire logic wire_i,
   output logic scl,
   output logic pull,
   output logic [8:0] res,
   output logic res_tgl
);
   // ***************
   // bit level
   // ***************
   initial
   begin
      scl = 1'h1;
      pull = 1'h0; // both pins released while idle
      res = 9'h000;
      res_tgl = 1'h0;
   end

   // long low phase: the slave answers about 4 clk after scl falls
   task automatic bitx(input logic b, output logic r);
      @(posedge clk) scl <= 1'h0;
      repeat (2) @(posedge clk);
      pull <= ~b; // data moves only with scl low
      repeat (4) @(posedge clk);
      scl <= 1'h1;
      @(posedge clk);
      r = wire_i;
   endtask

   // p low gives START, p high gives STOP
   task automatic cond(input logic p);
      @(posedge clk) scl <= 1'h0;
      repeat (2) @(posedge clk);
      pull <= p;
      repeat (4) @(posedge clk);
      scl <= 1'h1;
      repeat (4) @(posedge clk);
      pull <= ~p; // edge with scl high frames a transfer
      repeat (4) @(posedge clk);
   endtask

   // START, also as repeated start
   task automatic open_frame();
      cond(1'h0);
   endtask

   task automatic close_frame();
      cond(1'h1);
   endtask

   task automatic wr_byte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r); // msb first
      bitx(1'h1, r); // ninth pulse left to the slave
      res = {~r, d};
      res_tgl = ~res_tgl;
   endtask

   task automatic rd_byte(input logic mack);
      logic [7:0] d;
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(1'h1, d[i]);
      bitx(~mack, r);
      res = {1'h0, d};
      res_tgl = ~res_tgl;
   endtask
endmodule

// >>> bench/eep_slave_chk.sv
/* Assertion checker for the two-wire slave port.
   Assumes pin-level scl_i and sda_i at the top ports, one clock. */
`timescale 1ns/1ps
module eep_slave_chk #(
   parameter int unsigned WR_CYCLES = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic busy
);
   import eep_pkg::*;
   // ***************
   // bit counter since START
   // ***************
   logic scl_q, sda_q;
   logic [4:0] cnt_q;
   logic [7:0] sh_q;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
         cnt_q <= 5'h00;
         sh_q <= 8'h00;
      end
      else
      begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         if (scl_i && scl_q && sda_q && !sda_i)
            cnt_q <= 5'h00;
         else if (scl_i && !scl_q && cnt_q != 5'h1F)
            cnt_q <= cnt_q + 5'h01;
         if (scl_i && !scl_q)
            sh_q <= {sh_q[6:0], sda_i};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ***************
   // assertions
   // ***************
   a_open_drain: assert property (sda_o == 1'h0)
      else $error("data pin driven high");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data output changed with clock high");
   a_stop_idle: assert property
      (scl_i && scl_q && !sda_q && sda_i |=> !sda_oe [*8])
      else $error("line held after stop");
   a_ack_ninth: assert property
      ($rose(sda_oe) && cnt_q < 5'h09 |-> cnt_q == 5'h08)
      else $error("acknowledge before ninth pulse");
   a_ack_match: assert property
      ($fell(scl_i) && cnt_q == 5'h08 && sh_q[7:1] == DEV_ADDR && !busy
       |-> ##[3:6] sda_oe) else $error("own address not acknowledged");
   a_no_match: assert property
      ($fell(scl_i) && cnt_q == 5'h08 && (sh_q[7:1] != DEV_ADDR || busy)
       |-> !sda_oe [*8]) else $error("foreign address acknowledged");
   a_ack_stands: assert property
      ($rose(sda_oe) && cnt_q == 5'h08 |-> sda_oe [*6])
      else $error("acknowledge too short");
   a_busy_rise: assert property
      ($rose(busy) |-> sda_oe && !$past(sda_oe, 2))
      else $error("busy without accepted byte");
   c_ack: cover property ($fell(scl_i) && cnt_q == 5'h08 && !busy);
   c_busy: cover property ($rose(busy));
   c_stop: cover property (scl_i && scl_q && !sda_q && sda_i);
endmodule

bind eep_slave eep_slave_chk #(.WR_CYCLES(WR_CYCLES)) eep_slave_chk_inst (
   .clk(clk),
   .rst_b(rst_b),
   .scl_i(scl_i),
   .sda_i(sda_i),
   .sda_o(sda_o),
   .sda_oe(sda_oe),
   .busy(busy)
);

// >>> bench/eep_slave_tb.sv
/* Self-checking bench of the two-wire slave port.
   Assumes the master model beside it and the checker bound in. */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("Error %s expected %h seen %h", nm, e, g); \
      end \
   end
module eep_slave_tb;
   import eep_pkg::*;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic scl, pull, res_tgl, sda_o, sda_oe, busy, sda_w;
   logic [8:0] res, exp_v;
   logic [8:0] q[$];
   logic [7:0] mem[32];
   logic [6:0] bad[4] = '{7'h51, 7'h10, 7'h58, 7'h70};
   int errors = 0;
   int comparisons = 0;
   int seed = 18852;
   int n;
   always #20 clk = ~clk;
   // released wire floats high through the pull-up
   assign sda_w = (sda_oe ? sda_o : 1'h1) & ~pull;
   eep_slave #(.WR_CYCLES(40)) eep_slave_inst (
      .clk(clk),
      .rst_b(rst_b),
      .scl_i(scl),
      .sda_i(sda_w),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .busy(busy)
   );
   eep_bm eep_bm_inst (
      .clk(clk),
      .wire_i(sda_w),
      .scl(scl),
      .pull(pull),
      .res(res),
      .res_tgl(res_tgl)
   );
   // ***************
   // result watcher
   // ***************
   always @(res_tgl)
   begin
      exp_v = 9'h1FF;
      if (q.size() != 0)
         exp_v = q.pop_front();
      // the toggle's power-up value is no result
      if (rst_b)
         `CHK("byte", exp_v, res)
   end
   task automatic wr(input logic [7:0] d, input logic a);
      q.push_back({a, d});
      eep_bm_inst.wr_byte(d);
   endtask
   task automatic rd(input logic [7:0] d, input logic m);
      q.push_back({1'h0, d});
      eep_bm_inst.rd_byte(m);
   endtask
   task automatic summarize();
      $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ***************
   // scenarios
   // ***************
   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      repeat (8) @(posedge clk);
      foreach (bad[i])
      begin
         eep_bm_inst.open_frame();
         wr({bad[i], i[0]}, 1'h0);
         wr(8'hA5, 1'h0); // ignored until next start
         eep_bm_inst.close_frame();
      end
      $display("Test foreign address done");
      foreach (mem[i])
         mem[i] = 8'($random(seed));
      eep_bm_inst.open_frame();
      wr({DEV_ADDR, 1'h0}, 1'h1);
      wr(8'hF0, 1'h1); // top bit dropped
      foreach (mem[i])
         wr(mem[i], 1'h1); // wraps past 7F
      wr(8'h3C, 1'h0); // write queue full
      eep_bm_inst.close_frame();
      eep_bm_inst.open_frame();
      wr({DEV_ADDR, 1'h0}, 1'h0); // refused while busy
      eep_bm_inst.close_frame();
      n = 0;
      while (busy !== 1'h0 && n < 5000)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("busy", 1'h0, busy)
      $display("Test write and fill done");
      eep_bm_inst.open_frame();
      wr({DEV_ADDR, 1'h0}, 1'h1);
      wr(8'h70, 1'h1);
      eep_bm_inst.open_frame();
      wr({DEV_ADDR, 1'h1}, 1'h1);
      for (int i = 0; i < 31; i++)
         rd(mem[i], i < 30);
      eep_bm_inst.close_frame();
      eep_bm_inst.open_frame();
      wr({DEV_ADDR, 1'h1}, 1'h1);
      rd(mem[31], 1'h0); // current address read
      eep_bm_inst.close_frame();
      $display("Test read back done");
      `CHK("pending", 0, q.size())
      summarize();
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      errors++;
      summarize();
   end
endmodule
